// ### rtl/atsr_pkg.sv
package atsr_pkg;

  // ----------------------------------------
  // Table geometry
  // ----------------------------------------
  localparam int DEPTH = 16;  // Entries in the address table
  localparam int IDX_W = 4;   // Index width
  localparam logic [4:0] LAST_IDX = 5'h0F;  // Last index of a scan
  localparam logic [4:0] SCAN_END = 5'h10;  // Issue count that ends a scan

  // One table entry
  typedef struct packed {
    logic valid;        // Entry holds a live station
    logic is_static;    // Owned by management, never learned or aged
    logic age;          // Recently learned or hit
    logic [2:0] prio;   // Address based QoS priority
    logic [11:0] vid;   // VLAN identifier
    logic [47:0] addr;  // Station address, bit 47 is the group bit
    logic [16:0] map;   // Port number (low 5 bits) or multicast map
  } atsr_entry_type;

  localparam int ENTRY_W = $bits(atsr_entry_type);

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_SEARCH_CTRL = 8'h00;
  localparam logic [7:0] OFF_AGE_PERIOD = 8'h04;
  localparam logic [7:0] OFF_STG_ADDR_LO = 8'h10;
  localparam logic [7:0] OFF_STG_HI = 8'h14;
  localparam logic [7:0] OFF_STG_ATTR = 8'h18;
  localparam logic [7:0] OFF_ENTRY_CMD = 8'h1C;
  localparam logic [7:0] OFF_RES_LO = 8'h40;
  localparam logic [7:0] OFF_RES_HI = 8'h44;
  localparam logic [7:0] OFF_RES_ATTR = 8'h48;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int VID_LSB = 16;     // Vid in the upper result word
  localparam int STG_STATIC = 20;  // Static bit in staging attribute
  localparam int STG_VALID = 21;   // Valid bit in staging attribute
  localparam int STG_PRIO = 24;    // Priority in staging attribute
  localparam int CMD_GO = 8;       // Entry write trigger and pending bit
  localparam int CTRL_FOUND = 1;   // Search found flag

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [15:0] AGE_PERIOD_RST = 16'h0000;  // Aging off
  localparam int CLK_PERIOD_NS = 10;
  localparam int AGE_UNIT_NS = 1000;
  localparam int AGE_UNIT_CYCLES = AGE_UNIT_NS / CLK_PERIOD_NS;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_CLEAR = 3'b000,
    ST_IDLE = 3'b001,
    ST_LRN_SCAN = 3'b010,
    ST_LRN_WR = 3'b011,
    ST_SRCH_SCAN = 3'b100,
    ST_AGE_SCAN = 3'b101
  } atsr_state_type;

endpackage

// ### rtl/atsr_entry_mem.sv
`timescale 1ns/100ps
// Entry storage, one write port and one registered read port
module atsr_entry_mem
  import atsr_pkg::*;
#(
  parameter int WIDTH = ENTRY_W,
  parameter int AW = IDX_W
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [AW-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data
);

  logic [WIDTH-1:0] cells [0:(1<<AW)-1];  // Storage, cleared by the sequencer

  // Write port, no reset: contents are wiped by a clear sweep
  always_ff @(posedge pclk)
  begin
    if (wr_en)
    begin
      cells[wr_idx] <= wr_data;
    end
  end

  // Read data leaves from a register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= cells[rd_idx];
    end
  end

endmodule

// ### rtl/atsr_tick_timer.sv
`timescale 1ns/100ps
// Period timer: one pulse every period units; a period of zero stops it
module atsr_tick_timer
  import atsr_pkg::*;
#(
  parameter int UNIT_CYCLES = AGE_UNIT_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] period,
  output logic tick
);

  logic [15:0] pre;    // Cycles within one unit
  logic [15:0] units;  // Units elapsed
  wire unit_end = (pre == 16'(UNIT_CYCLES - 1));
  wire period_end = unit_end && (units + 16'h0001 >= period);

  // Prescaler and unit counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre <= 16'h0000;
      units <= 16'h0000;
      tick <= 1'b0;
    end
    else
    begin
      pre <= unit_end ? 16'h0000 : pre + 16'h0001;
      if (period == 16'h0000 || period_end)
      begin
        units <= 16'h0000;
      end
      else if (unit_end)
      begin
        units <= units + 16'h0001;
      end
      tick <= period_end && (period != 16'h0000);
    end
  end

endmodule

// ### rtl/atsr_top.sv
`timescale 1ns/100ps
module atsr_top
  import atsr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic learn_valid,
  output logic learn_ready,
  input wire logic [11:0] learn_vid,
  input wire logic [47:0] learn_addr,
  input wire logic [4:0] learn_port
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  atsr_state_type state;       // Sequencer state
  atsr_state_type next_state;  // Next sequencer state
  logic [4:0] scan_cnt;        // Reads issued in the current sweep
  logic cmp_live;              // Read data this cycle belongs to a sweep
  logic cmp_last;              // That data is the last of the sweep
  logic [IDX_W-1:0] cmp_idx;   // Index of the data being examined
  atsr_entry_type rd_entry;    // Entry read back from storage
  logic [ENTRY_W-1:0] rd_raw;  // Raw read data
  logic wr_en;                 // Storage write strobe
  logic [IDX_W-1:0] wr_idx;    // Storage write index
  atsr_entry_type wr_data;     // Storage write data
  atsr_entry_type res;         // Latched search result
  logic search_busy;           // Search requested or running
  logic search_found;          // Last search located an entry
  logic [IDX_W-1:0] search_base;  // Next search resumes here
  logic [15:0] age_period;     // Aging period in units
  logic age_tick;              // Aging period elapsed
  logic age_pend;              // Aging sweep owed
  logic [31:0] stg_addr_lo;    // Staged address low word
  logic [27:0] stg_hi;         // Staged vid and address high part
  logic [26:0] stg_attr;       // Staged map, flags and priority
  logic [IDX_W-1:0] stg_idx;   // Target of a management write
  logic mgmt_pend;             // Management write owed
  logic [11:0] lrn_vid;        // Latched learn request
  logic [47:0] lrn_addr;
  logic [4:0] lrn_port;
  logic lrn_hit;               // Learn request matched an entry
  logic [IDX_W-1:0] lrn_hit_idx;
  atsr_entry_type lrn_hit_entry;
  logic lrn_free_ok;           // A free slot was seen
  logic [IDX_W-1:0] lrn_free_idx;
  atsr_entry_type lrn_new;     // Entry written by learning
  atsr_entry_type age_entry;   // Entry written by aging
  atsr_entry_type stg_entry;   // Entry written by management

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup = psel && !penable;
  wire acc_wr = psel && penable && pwrite && pready;
  wire hit_ctrl = (paddr == OFF_SEARCH_CTRL);
  wire hit_age = (paddr == OFF_AGE_PERIOD);
  wire hit_slo = (paddr == OFF_STG_ADDR_LO);
  wire hit_shi = (paddr == OFF_STG_HI);
  wire hit_sat = (paddr == OFF_STG_ATTR);
  wire hit_cmd = (paddr == OFF_ENTRY_CMD);
  wire hit_rlo = (paddr == OFF_RES_LO);
  wire hit_rhi = (paddr == OFF_RES_HI);
  wire hit_rat = (paddr == OFF_RES_ATTR);
  wire addr_ok = hit_ctrl | hit_age | hit_slo | hit_shi | hit_sat | hit_cmd
    | hit_rlo | hit_rhi | hit_rat;
  wire start_wr = acc_wr && hit_ctrl && pwdata[0];
  wire go_wr = acc_wr && hit_cmd && pwdata[CMD_GO];

  // Attribute word: group bit swaps port for map view
  wire grp = res.addr[47];
  wire [4:0] port_field = grp ? res.map[5:1] : res.map[4:0];
  wire bit5_field = grp ? res.map[0] : res.is_static;
  wire [10:0] maphi_field = grp ? res.map[16:6] : 11'h000;
  wire [31:0] attr_word = {10'h000, maphi_field, port_field, bit5_field,
    res.age, res.valid, res.prio};
  wire [31:0] hi_word = {4'h0, res.vid, res.addr[47:32]};

  // Read mux; unused and reserved bits read as zero, except staging attribute bits 19:17 and 23:22, which read back as written
  wire [31:0] rd_mux =
    hit_ctrl ? {30'h0, search_found, search_busy} :
    hit_age ? {16'h0000, age_period} :
    hit_slo ? stg_addr_lo :
    hit_shi ? {4'h0, stg_hi} :
    hit_sat ? {5'h00, stg_attr} :
    hit_cmd ? {23'h0, mgmt_pend, 4'h0, stg_idx} :
    hit_rlo ? res.addr[31:0] :
    hit_rhi ? hi_word :
    hit_rat ? attr_word : 32'h0;

  // ----------------------------------------
  // APB answer, zero wait states
  // ----------------------------------------
  // Read data is captured in setup so the answer comes from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= setup && !pwrite ? rd_mux : 32'h0;
      pready <= setup;
      pslverr <= setup && !addr_ok;
    end
  end

  // Software written settings and staging
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      age_period <= AGE_PERIOD_RST;
      stg_addr_lo <= 32'h0;
      stg_hi <= 28'h0;
      stg_attr <= 27'h0;
      stg_idx <= '0;
    end
    else if (acc_wr)
    begin
      if (hit_age) age_period <= pwdata[15:0];
      if (hit_slo) stg_addr_lo <= pwdata;
      if (hit_shi) stg_hi <= pwdata[27:0];
      if (hit_sat) stg_attr <= pwdata[26:0];
      if (hit_cmd) stg_idx <= pwdata[IDX_W-1:0];
    end
  end

  // ----------------------------------------
  // Storage and timer
  // ----------------------------------------
  wire scanning = (state == ST_LRN_SCAN) || (state == ST_SRCH_SCAN)
    || (state == ST_AGE_SCAN);
  wire issuing = scanning && (scan_cnt < SCAN_END);
  wire [IDX_W-1:0] rd_idx = (state == ST_SRCH_SCAN) ?
    search_base + scan_cnt[IDX_W-1:0] : scan_cnt[IDX_W-1:0];
  assign rd_entry = atsr_entry_type'(rd_raw);

  atsr_entry_mem #(.WIDTH(ENTRY_W), .AW(IDX_W)) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .rd_idx(rd_idx),
    .rd_data(rd_raw),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data)
  );

  atsr_tick_timer #(.UNIT_CYCLES(AGE_UNIT_CYCLES)) u_age_timer (
    .pclk(pclk),
    .presetn(presetn),
    .period(age_period),
    .tick(age_tick)
  );

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  wire take_learn = (state == ST_IDLE) && learn_valid && learn_ready;
  wire mgmt_wr = (state == ST_IDLE) && !take_learn && mgmt_pend;
  wire clr_wr = (state == ST_CLEAR);
  wire lrn_match = rd_entry.valid && (rd_entry.addr == lrn_addr)
    && (rd_entry.vid == lrn_vid);
  wire lrn_free = !rd_entry.valid && !rd_entry.is_static;
  wire lrn_wr = (state == ST_LRN_WR) && !lrn_addr[47]
    && (lrn_hit ? !lrn_hit_entry.is_static : lrn_free_ok);
  // Aging touches only valid, non-static entries
  wire age_wr = (state == ST_AGE_SCAN) && cmp_live && rd_entry.valid
    && !rd_entry.is_static;
  wire srch_hit = (state == ST_SRCH_SCAN) && cmp_live && rd_entry.valid;
  wire sweep_done = cmp_live && cmp_last;

  // Write data for each writer
  always_comb
  begin
    lrn_new = lrn_hit ? lrn_hit_entry : '0;
    lrn_new.valid = 1'b1;
    lrn_new.age = 1'b1;
    lrn_new.vid = lrn_vid;
    lrn_new.addr = lrn_addr;
    lrn_new.map = {12'h000, lrn_port};
    age_entry = rd_entry;
    age_entry.age = 1'b0;
    age_entry.valid = rd_entry.age;
    stg_entry.valid = stg_attr[STG_VALID];
    stg_entry.is_static = stg_attr[STG_STATIC];
    stg_entry.age = stg_attr[STG_VALID];
    stg_entry.prio = stg_attr[STG_PRIO+2:STG_PRIO];
    stg_entry.vid = stg_hi[27:16];
    stg_entry.addr = {stg_hi[15:0], stg_addr_lo};
    stg_entry.map = stg_attr[16:0];
  end

  // Writer selection, one per cycle by state
  assign wr_en = clr_wr || mgmt_wr || lrn_wr || age_wr;
  assign wr_idx = clr_wr ? scan_cnt[IDX_W-1:0] : mgmt_wr ? stg_idx :
    lrn_wr ? (lrn_hit ? lrn_hit_idx : lrn_free_idx) : cmp_idx;
  assign wr_data = clr_wr ? '0 : mgmt_wr ? stg_entry :
    lrn_wr ? lrn_new : age_entry;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Learning first, then management, search and aging
  always_comb
  begin
    next_state = state;
    case (state)
      ST_CLEAR:
        if (scan_cnt == LAST_IDX) next_state = ST_IDLE;
      ST_IDLE:
        if (take_learn) next_state = ST_LRN_SCAN;
        else if (mgmt_pend) next_state = ST_IDLE;
        else if (search_busy) next_state = ST_SRCH_SCAN;
        else if (age_pend) next_state = ST_AGE_SCAN;
      ST_LRN_SCAN:
        if (sweep_done) next_state = ST_LRN_WR;
      ST_LRN_WR:
        next_state = ST_IDLE;
      ST_SRCH_SCAN:
        if (srch_hit || sweep_done) next_state = ST_IDLE;
      ST_AGE_SCAN:
        if (sweep_done) next_state = ST_IDLE;
      default:
        next_state = ST_CLEAR;
    endcase
  end

  // State, sweep counter and compare pipeline
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_CLEAR;
      scan_cnt <= 5'h00;
      cmp_live <= 1'b0;
      cmp_last <= 1'b0;
      cmp_idx <= '0;
    end
    else
    begin
      state <= next_state;
      scan_cnt <= (state != next_state) ? 5'h00 :
        (issuing || clr_wr) ? scan_cnt + 5'h01 : scan_cnt;
      cmp_live <= issuing && (state == next_state);
      cmp_last <= issuing && (scan_cnt == LAST_IDX);
      cmp_idx <= rd_idx;
    end
  end

  // Learn port handshake; ready only with nothing else owed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      learn_ready <= 1'b0;
    end
    else
    begin
      learn_ready <= (next_state == ST_IDLE) && !take_learn && !mgmt_pend
        && !search_busy && !age_pend;
    end
  end

  // Learn request capture and sweep tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lrn_vid <= 12'h000;
      lrn_addr <= 48'h0;
      lrn_port <= 5'h00;
      lrn_hit <= 1'b0;
      lrn_hit_idx <= '0;
      lrn_hit_entry <= '0;
      lrn_free_ok <= 1'b0;
      lrn_free_idx <= '0;
    end
    else if (take_learn)
    begin
      lrn_vid <= learn_vid;
      lrn_addr <= learn_addr;
      lrn_port <= learn_port;
      lrn_hit <= 1'b0;
      lrn_free_ok <= 1'b0;
    end
    else if (state == ST_LRN_SCAN && cmp_live)
    begin
      // A hit refreshes the entry; otherwise the first free slot is taken
      if (lrn_match && !lrn_hit)
      begin
        lrn_hit <= 1'b1;
        lrn_hit_idx <= cmp_idx;
        lrn_hit_entry <= rd_entry;
      end
      if (lrn_free && !lrn_free_ok)
      begin
        lrn_free_ok <= 1'b1;
        lrn_free_idx <= cmp_idx;
      end
    end
  end

  // Search result and pending flags; a set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res <= '0;
      search_busy <= 1'b0;
      search_found <= 1'b0;
      search_base <= '0;
      age_pend <= 1'b0;
      mgmt_pend <= 1'b0;
    end
    else
    begin
      if (srch_hit)
      begin
        res <= rd_entry;
        search_found <= 1'b1;
        search_base <= cmp_idx + 4'h1;
      end
      else if (state == ST_SRCH_SCAN && sweep_done)
      begin
        search_found <= 1'b0;
      end
      search_busy <= start_wr
        || (search_busy && !srch_hit && !(state == ST_SRCH_SCAN && sweep_done));
      age_pend <= age_tick || (age_pend && next_state != ST_AGE_SCAN);
      mgmt_pend <= go_wr || (mgmt_pend && !mgmt_wr);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire rd_setup = setup && !pwrite;

  read_quiet_a: assert property (rd_setup && state != ST_SRCH_SCAN ##1 1 |->
    $stable(res) || $past(state) == ST_SRCH_SCAN)
    else $error("result changed by a read");
  res_vid_a: assert property (rd_setup && hit_rhi |=>
    prdata[27:16] == $past(res.vid) && prdata[31:28] == 4'h0)
    else $error("vid field wrong");
  port_field_a: assert property (rd_setup && hit_rat && !res.addr[47] |=>
    prdata[10:6] == $past(res.map[4:0]) && prdata[21:11] == 11'h000)
    else $error("unicast port field wrong");
  map_field_a: assert property (rd_setup && hit_rat && res.addr[47] |=>
    prdata[5] == $past(res.map[0]) && prdata[21:11] == $past(res.map[16:6]))
    else $error("multicast map field wrong");
  static_keep_a: assert property (state == ST_AGE_SCAN && cmp_live
    && rd_entry.is_static |-> !wr_en)
    else $error("static entry aged");
  learn_age_a: assert property (lrn_wr |-> wr_data.age && wr_data.valid
    && !(lrn_hit && lrn_hit_entry.is_static))
    else $error("learned entry without age");
  age_expire_a: assert property (age_wr && !rd_entry.age |->
    wr_en && !wr_data.valid && wr_idx == cmp_idx)
    else $error("unused entry not expired");
  age_clear_a: assert property (age_wr && rd_entry.age |->
    wr_data.valid && !wr_data.age)
    else $error("age flag not cleared");
  free_slot_a: assert property (state == ST_LRN_SCAN && cmp_live && lrn_free
    && !lrn_free_ok |=> lrn_free_ok && lrn_free_idx == $past(cmp_idx))
    else $error("free slot missed");
  search_latch_a: assert property (srch_hit |=> res == $past(rd_entry)
    && state == ST_IDLE && search_found)
    else $error("search result not latched");
  clear_empty_a: assert property (state == ST_CLEAR |-> wr_en && !wr_data.valid)
    else $error("clear sweep left valid entry");
  prio_field_a: assert property (rd_setup && hit_rat |=>
    prdata[2:0] == $past(res.prio) && prdata[31:22] == 10'h000)
    else $error("priority field wrong");

  learn_cov_c: cover property (lrn_wr && !lrn_hit);
  search_cov_c: cover property (srch_hit);
  expire_cov_c: cover property (age_wr && !rd_entry.age);
  mgmt_cov_c: cover property (mgmt_wr);

endmodule

// ### tb/atsr_top_test.sv
`timescale 1ns/100ps
module atsr_top_test
  import atsr_pkg::*;
;
  // ----------------------------------------
  // Stimulus signals and bookkeeping
  // ----------------------------------------
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic learn_valid = 1'h0;
  logic learn_ready;
  logic [11:0] learn_vid = 12'h000;
  logic [47:0] learn_addr = 48'h0;
  logic [4:0] learn_port = 5'h00;
  logic [64:0] note_q[$];  // Expected {error, data, mask} per transfer
  logic [64:0] nt;
  logic [31:0] rv;
  logic [47:0] ra;
  logic [11:0] rvid;
  logic [16:0] rmap;
  logic [2:0] rp;
  localparam logic [31:0] z = 32'h0;
  localparam logic [31:0] ones = 32'hFFFFFFFF;
  int err_total = 0;
  int checked = 0;

  atsr_top i_atsr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .learn_valid(learn_valid), .learn_ready(learn_ready),
    .learn_vid(learn_vid), .learn_addr(learn_addr), .learn_port(learn_port));

  // Free running 100 MHz clock
  always #5 pclk = ~pclk;

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  // Masked data compare; the error flag is always compared
  task automatic cmp_resp(input logic [32:0] got, input logic [32:0] exp,
    input logic [31:0] msk);
    checked++;
    if (((got[31:0] & msk) !== (exp[31:0] & msk)) || (got[32] !== exp[32]))
    begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Completed transfer takes the oldest note off the queue
  always @(posedge pclk)
  begin
    if (psel && penable && pready && note_q.size() > 0)
    begin
      nt = note_q.pop_front();
      cmp_resp({pslverr, prdata}, nt[64:32], nt[31:0]);
    end
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog, far beyond the well under two thousand cycles the run needs
  initial
  begin
    #100000;
    err_total++;
    complete_run();
  end

  // ----------------------------------------
  // Bus and entry tasks
  // ----------------------------------------
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
    input logic [31:0] e, input logic [31:0] m, input logic ee, output logic [31:0] r);
    int n;
    n = 0;
    note_q.push_back({ee, e, m});
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Wait for the answer; a missing one counts as a mismatch
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1)
      err_total++;
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Poll until a busy or pending bit drops, bounded
  task automatic wait_clr(input logic [7:0] a, input int b);
    int n;
    n = 0;
    rv = ones;
    while (rv[b] !== 1'h0 && n < 100)
    begin
      apb(a, 1'h0, z, z, z, 1'h0, rv);
      n++;
    end
    // A bit that never drops is a hang, counted as a mismatch
    if (rv[b] !== 1'h0)
      err_total++;
  endtask

  // Mgmt write of one entry through the staging registers
  task automatic stage(input logic [47:0] a, input logic [11:0] v, input logic [16:0] mp,
    input logic st, input logic vl, input logic [2:0] p, input logic [3:0] ix);
    apb(OFF_STG_ADDR_LO, 1'h1, a[31:0], z, z, 1'h0, rv);
    apb(OFF_STG_HI, 1'h1, {4'h0, v, a[47:32]}, z, z, 1'h0, rv);
    apb(OFF_STG_ATTR, 1'h1, {5'h00, p, 2'h0, vl, st, 3'h0, mp}, z, z, 1'h0, rv);
    apb(OFF_ENTRY_CMD, 1'h1, {23'h0, 1'h1, 4'h0, ix}, z, z, 1'h0, rv);
    wait_clr(OFF_ENTRY_CMD, CMD_GO);
  endtask

  // Start a search and check the found flag once it ends
  task automatic search(input logic f);
    apb(OFF_SEARCH_CTRL, 1'h1, 32'h1, z, z, 1'h0, rv);
    wait_clr(OFF_SEARCH_CTRL, 0);
    apb(OFF_SEARCH_CTRL, 1'h0, z, {30'h0, f, 1'h0}, 32'h3, 1'h0, rv);
  endtask

  // Attribute word as the found entry must show it
  function automatic logic [31:0] attr(input logic mc, input logic [16:0] mp,
    input logic st, input logic ag, input logic vl, input logic [2:0] p);
    if (mc)
      return {10'h0, mp, ag, vl, p};
    return {21'h0, mp[4:0], st, ag, vl, p};
  endfunction

  // Result read twice: a read must not disturb the next one
  task automatic check_res(input logic [47:0] a, input logic [11:0] v,
    input logic [31:0] at, input logic [31:0] m);
    repeat (2)
    begin
      apb(OFF_RES_LO, 1'h0, z, a[31:0], ones, 1'h0, rv);
      apb(OFF_RES_HI, 1'h0, z, {4'h0, v, a[47:32]}, ones, 1'h0, rv);
      apb(OFF_RES_ATTR, 1'h0, z, at, m, 1'h0, rv);
    end
  endtask

  // Learn request held until taken; table updates about 19 cycles on
  task automatic learn(input logic [47:0] a, input logic [11:0] v, input logic [4:0] pt);
    int n;
    n = 0;
    @(posedge pclk);
    learn_valid <= 1'h1;
    learn_addr <= a;
    learn_vid <= v;
    learn_port <= pt;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (learn_ready !== 1'h1 && n < 200);
    if (learn_ready !== 1'h1)
      err_total++;
    learn_valid <= 1'h0;
    repeat (30) @(posedge pclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rv = $urandom(32'h657A);
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    // Let the table clear sweep finish
    repeat (30) @(posedge pclk);
    for (int i = 0; i < 3; i++)
      apb(OFF_RES_LO + 8'(4 * i), 1'h0, z, z, ones, 1'h0, rv);
    apb(8'h4C, 1'h1, ones, z, z, 1'h1, rv);
    apb(8'h4C, 1'h0, z, z, ones, 1'h1, rv);
    apb(OFF_RES_LO, 1'h1, ones, z, z, 1'h0, rv);
    apb(OFF_RES_LO, 1'h0, z, z, ones, 1'h0, rv);
    // Multicast entry, then management invalidation
    ra = {1'h1, 15'($urandom), $urandom};
    rvid = 12'($urandom);
    rmap = 17'($urandom);
    rp = 3'($urandom);
    stage(ra, rvid, rmap, 1'h0, 1'h1, rp, 4'h3);
    search(1'h1);
    check_res(ra, rvid, attr(1'h1, rmap, 1'h0, 1'h1, 1'h1, rp), ones);
    stage(ra, rvid, rmap, 1'h0, 1'h0, rp, 4'h3);
    search(1'h0);
    // Static unicast survives aging and a learn of its own address
    ra = {1'h0, 15'($urandom), $urandom};
    rmap = {12'h000, 5'($urandom)};
    stage(ra, rvid, rmap, 1'h1, 1'h1, rp, 4'h5);
    apb(OFF_AGE_PERIOD, 1'h1, 32'h1, z, z, 1'h0, rv);
    repeat (500) @(posedge pclk);
    learn(ra, rvid, ~rmap[4:0]);
    search(1'h1);
    check_res(ra, rvid, attr(1'h0, rmap, 1'h1, 1'h1, 1'h1, rp), ones);
    apb(OFF_AGE_PERIOD, 1'h1, z, z, z, 1'h0, rv);
    stage(ra, rvid, rmap, 1'h1, 1'h0, rp, 4'h5);
    // Group address learn is dropped
    learn({1'h1, 15'($urandom), $urandom}, rvid, 5'h01);
    search(1'h0);
    // Learned unicast, refreshed with a new port, aged out; priority unchecked
    ra = {1'h0, 15'($urandom), $urandom};
    learn(ra, rvid, ~rmap[4:0]);
    learn(ra, rvid, rmap[4:0]);
    search(1'h1);
    check_res(ra, rvid, attr(1'h0, rmap, 1'h0, 1'h1, 1'h1, 3'h0), 32'hFFFFFFF8);
    apb(OFF_AGE_PERIOD, 1'h1, 32'h1, z, z, 1'h0, rv);
    // Two aging periods of 100 cycles each are enough for expiry
    repeat (400) @(posedge pclk);
    search(1'h0);
    @(posedge pclk);
    complete_run();
  end
endmodule
